// file: verilog/balu_core.sv
// Purpose : 8-bit arithmetic and logic datapath with 16-bit pair ops
// Assumes : Decoder holds operands steady while BUSY_O is high
// Notes   : Results and flags appear one edge after the request, the pair high byte one edge later
`include "balu_params.svh"
`default_nettype none
module balu_core
  import balu_pkg::*;
(
  input  wire logic              CLK_I,        // Core clock 125 MHz
  input  wire logic              SYS_RST_I,    // Synchronous reset, active high
  input  wire logic              START_I,      // One-cycle request
  input  wire balu_pkg::balu_op_t OP_I,        // Operation code
  input  wire logic [7:0]        DST_I,        // Destination value (pair low)
  input  wire logic [7:0]        DST_HI_I,     // Pair high byte
  input  wire logic [7:0]        SRC_REG_I,    // Source register value
  input  wire logic [7:0]        IMM_I,        // Immediate constant or mask
  input  wire logic              USE_IMM_I,    // Take IMM_I instead of SRC_REG_I for ADD, ADC, SUB, SBC, AND and OR
  input  wire logic [7:0]        SREG_I,       // Current status flags
  output logic      [7:0]        RESULT_O,     // Result byte
  output logic                   WE_O,         // Write result, high one cycle for byte ops, two cycles in a row for word ops
  output logic                   WE_HI_O,      // Result is the pair high byte
  output logic      [7:0]        SREG_O,       // New status flags
  output logic                   SREG_WE_O,    // Write flags, one-cycle pulse
  output logic                   BUSY_O        // Second word cycle pending
);
  import balu_pkg::*;

  // ==========================================================
  // State record
  typedef struct packed
  {
    balu_phase_t phase;   // Sequencer phase
    logic [7:0]  hi;      // Pair high result waiting
    logic [7:0]  res;     // Result register
    logic        we;      // Result strobe
    logic        we_hi;   // High byte strobe
    logic [7:0]  flg;     // Flags register
    logic        fwe;     // Flag strobe
    logic        busy;    // Second word cycle pending
  } balu_state_t;

  balu_state_t st_reg;    // Registered state
  balu_state_t st_next;   // Next state

  // ==========================================================
  // Operand select and arithmetic
  logic [7:0]  opb;       // Second operand
  logic        sub;       // Subtract form
  logic [8:0]  sum9;      // Add or subtract with carry out
  logic [7:0]  r8;        // Byte result
  logic        cin;       // Carry in
  logic        h_w;       // Half carry
  logic        v_w;       // Overflow
  logic [16:0] w17;       // Word result with carry
  logic [15:0] pair;      // Pair operand

  assign pair = {DST_HI_I, DST_I};

  // Picks operand and carry for the add/subtract family
  always_comb
  begin
    opb  = USE_IMM_I ? IMM_I : SRC_REG_I;
    sub  = 1'b0;
    cin  = 1'b0;
    unique case (OP_I)
      `BALU_OP_ADC: cin = SREG_I[`BALU_FLAG_C];
      `BALU_OP_SUB: sub = 1'b1;
      `BALU_OP_SBC:
      begin
        sub = 1'b1;
        cin = SREG_I[`BALU_FLAG_C];
      end
      default: cin = 1'b0;
    endcase
    if (sub)
      sum9 = {1'b0, DST_I} - {1'b0, opb} - {8'h00, cin};
    else
      sum9 = {1'b0, DST_I} + {1'b0, opb} + {8'h00, cin};
    r8 = sum9[7:0];
  end

  balu_flag_calc u_flag
  (
    .a_i   (DST_I),
    .b_i   (opb),
    .r_i   (r8),
    .sub_i (sub),
    .h_o   (h_w),
    .v_o   (v_w)
  );

  // Word sum or difference with the zero-extended constant
  assign w17 = (OP_I == `BALU_OP_SUBW) ? ({1'b0, pair} - {9'h000, IMM_I})
                                       : ({1'b0, pair} + {9'h000, IMM_I});

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [7:0] rr;       // Chosen result
    logic [7:0] f;        // Working flags
    logic       zn_v;     // Logic family flag update
    rr   = 8'h00;
    f    = SREG_I;
    zn_v = 1'b0;
    st_next       = st_reg;
    st_next.we    = 1'b0;
    st_next.we_hi = 1'b0;
    st_next.fwe   = 1'b0;
    unique case (st_reg.phase)
      BALU_IDLE:
      begin
        if (START_I)
        begin
          // Logic family: only Z, N and V change
          zn_v = OP_I inside {`BALU_OP_AND, `BALU_OP_OR, `BALU_OP_XOR, `BALU_OP_SETB,
                              `BALU_OP_CLRB, `BALU_OP_INC, `BALU_OP_DEC, `BALU_OP_TST,
                              `BALU_OP_CLR};
          unique case (OP_I)
            `BALU_OP_ADD, `BALU_OP_ADC, `BALU_OP_SUB, `BALU_OP_SBC:
            begin
              rr = r8;
              f[`BALU_FLAG_C] = sum9[8];
              f[`BALU_FLAG_H] = h_w;
              f[`BALU_FLAG_V] = v_w;
              f[`BALU_FLAG_N] = rr[7];
              f[`BALU_FLAG_Z] = (rr == 8'h00);
            end
            `BALU_OP_ADDW, `BALU_OP_SUBW:
            begin
              rr = w17[7:0];
              f[`BALU_FLAG_C] = w17[16];
              f[`BALU_FLAG_Z] = (w17[15:0] == 16'h0000);
              f[`BALU_FLAG_N] = w17[15];
              if (OP_I == `BALU_OP_ADDW)
                f[`BALU_FLAG_V] = ~DST_HI_I[7] & w17[15];
              else
                f[`BALU_FLAG_V] = DST_HI_I[7] & ~w17[15];
              f[`BALU_FLAG_S] = f[`BALU_FLAG_N] ^ f[`BALU_FLAG_V];
              st_next.hi    = w17[15:8];
              st_next.phase = BALU_WHI;
            end
            `BALU_OP_AND:  rr = DST_I & opb;
            `BALU_OP_OR:   rr = DST_I | opb;
            `BALU_OP_XOR:  rr = DST_I ^ SRC_REG_I;
            `BALU_OP_SETB: rr = DST_I | IMM_I;
            `BALU_OP_CLRB: rr = DST_I & ~IMM_I;
            `BALU_OP_INC:  rr = DST_I + 8'h01;
            `BALU_OP_DEC:  rr = DST_I - 8'h01;
            `BALU_OP_TST:  rr = DST_I & DST_I;
            `BALU_OP_CLR:  rr = DST_I ^ DST_I;
            `BALU_OP_COM:
            begin
              rr = 8'hFF - DST_I;
              f[`BALU_FLAG_C] = 1'b1;
              f[`BALU_FLAG_V] = 1'b0;
              f[`BALU_FLAG_N] = rr[7];
              f[`BALU_FLAG_Z] = (rr == 8'h00);
            end
            `BALU_OP_NEG:
            begin
              rr = 8'h00 - DST_I;
              f[`BALU_FLAG_C] = (rr != 8'h00);
              f[`BALU_FLAG_V] = (rr == 8'h80);
              f[`BALU_FLAG_H] = rr[3] | DST_I[3];
              f[`BALU_FLAG_N] = rr[7];
              f[`BALU_FLAG_Z] = (rr == 8'h00);
            end
            default: rr = DST_I;  // Unknown code: no write
          endcase
          if (zn_v)
          begin
            // Logic family: V cleared except INC at 7F and DEC at 80, C and H untouched
            f[`BALU_FLAG_V] = (OP_I == `BALU_OP_INC) ? (DST_I == 8'h7F) :
                              (OP_I == `BALU_OP_DEC) ? (DST_I == 8'h80) : 1'b0;
            f[`BALU_FLAG_N] = rr[7];
            f[`BALU_FLAG_Z] = (rr == 8'h00);
          end
          st_next.res = rr;
          st_next.flg = f;
          st_next.we  = (OP_I <= `BALU_OP_CLR);
          st_next.fwe = (OP_I <= `BALU_OP_CLR);
        end
      end
      BALU_WHI:
      begin
        // Second word cycle writes the high byte
        st_next.res   = st_reg.hi;
        st_next.we    = 1'b1;
        st_next.we_hi = 1'b1;
        st_next.phase = BALU_IDLE;
      end
      default: st_next.phase = BALU_IDLE;
    endcase
    // Busy mirrors the high-byte phase so the port comes from a flop
    st_next.busy = (st_next.phase == BALU_WHI);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      st_reg       <= '0;
      st_reg.phase <= BALU_IDLE;
      st_reg.flg   <= `BALU_FLAGS_RST;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign RESULT_O  = st_reg.res;
  assign WE_O      = st_reg.we;
  assign WE_HI_O   = st_reg.we_hi;
  assign SREG_O    = st_reg.flg;
  assign SREG_WE_O = st_reg.fwe;
  assign BUSY_O    = st_reg.busy;
endmodule : balu_core
`default_nettype wire

// file: common/balu_params.svh
// Purpose : Constants for the byte arithmetic logic unit
// Assumes : Included by bare name
// Notes   : Flag bit positions, operation codes and cycle counts
`ifndef BALU_PARAMS_SVH
`define BALU_PARAMS_SVH
// ==========================================================
// Flag positions in the 8-bit status word
`define BALU_FLAG_C 0
`define BALU_FLAG_Z 1
`define BALU_FLAG_N 2
`define BALU_FLAG_V 3
`define BALU_FLAG_S 4
`define BALU_FLAG_H 5
// ==========================================================
// Operation codes
`define BALU_OP_ADD  5'h00
`define BALU_OP_ADC  5'h01
`define BALU_OP_ADDW 5'h02
`define BALU_OP_SUB  5'h03
`define BALU_OP_SBC  5'h04
`define BALU_OP_SUBW 5'h05
`define BALU_OP_AND  5'h06
`define BALU_OP_OR   5'h07
`define BALU_OP_XOR  5'h08
`define BALU_OP_COM  5'h09
`define BALU_OP_NEG  5'h0A
`define BALU_OP_SETB 5'h0B
`define BALU_OP_CLRB 5'h0C
`define BALU_OP_INC  5'h0D
`define BALU_OP_DEC  5'h0E
`define BALU_OP_TST  5'h0F
`define BALU_OP_CLR  5'h10
// ==========================================================
// Reset values and cycle counts
`define BALU_FLAGS_RST 8'h00
`define BALU_BYTE_CYC  2'd1
`define BALU_WORD_CYC  2'd2
`endif

// file: common/balu_pkg.sv
// Purpose : Types for the byte arithmetic logic unit
// Assumes : Nothing
// Notes   : Constants live in balu_params.svh
`default_nettype none
package balu_pkg;
  // ==========================================================
  // Operation selector
  typedef logic [4:0] balu_op_t;
  // Sequencer phase
  typedef enum logic [1:0]
  {
    BALU_IDLE = 2'b00,
    BALU_WHI  = 2'b01
  } balu_phase_t;
endpackage : balu_pkg
`default_nettype wire

// file: verilog/balu_flag_calc.sv
// Purpose : Combinational flag maker for one 8-bit result
// Assumes : Operands and result come from the main datapath
// Notes   : Gives H and V for add and subtract forms
`default_nettype none
module balu_flag_calc
(
  input  wire logic [7:0] a_i,    // First operand
  input  wire logic [7:0] b_i,    // Second operand
  input  wire logic [7:0] r_i,    // Result
  input  wire logic       sub_i,  // High for subtract forms
  output var  logic       h_o,    // Half carry or borrow from bit 3
  output var  logic       v_o     // Signed overflow
);
  // ==========================================================
  // Flag equations
  always_comb
  begin
    if (sub_i)
    begin
      h_o = (~a_i[3] & b_i[3]) | (b_i[3] & r_i[3]) | (r_i[3] & ~a_i[3]);
      v_o = (a_i[7] & ~b_i[7] & ~r_i[7]) | (~a_i[7] & b_i[7] & r_i[7]);
    end
    else
    begin
      h_o = (a_i[3] & b_i[3]) | (b_i[3] & ~r_i[3]) | (~r_i[3] & a_i[3]);
      v_o = (a_i[7] & b_i[7] & ~r_i[7]) | (~a_i[7] & ~b_i[7] & r_i[7]);
    end
  end
endmodule : balu_flag_calc
`default_nettype wire

// file: testbench/balu_core_assertions.sv
// Purpose : Port-level checker for the byte arithmetic logic unit
// Assumes : Bound to balu_core, single clock domain
// Notes   : Codes and flag bits come from balu_params.svh
`include "balu_params.svh"
`default_nettype none
module balu_core_assertions
  import balu_pkg::*;
(
  input  wire logic                CLK_I,
  input  wire logic                SYS_RST_I,
  input  wire logic                START_I,
  input  wire balu_pkg::balu_op_t  OP_I,
  input  wire logic [7:0]          DST_I,
  input  wire logic [7:0]          DST_HI_I,
  input  wire logic [7:0]          SRC_REG_I,
  input  wire logic [7:0]          IMM_I,
  input  wire logic                USE_IMM_I,
  input  wire logic [7:0]          SREG_I,
  input  wire logic [7:0]          RESULT_O,
  input  wire logic                WE_O,
  input  wire logic                WE_HI_O,
  input  wire logic [7:0]          SREG_O,
  input  wire logic                SREG_WE_O,
  input  wire logic                BUSY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ==========================================================
  // Request taken and word-op decode
  logic take;
  logic word;
  assign take = START_I && !BUSY_O;
  assign word = OP_I == `BALU_OP_ADDW || OP_I == `BALU_OP_SUBW;
  sequence s_lo;
    WE_O && SREG_WE_O && BUSY_O && !WE_HI_O;
  endsequence
  sequence s_hi;
    WE_O && WE_HI_O && !SREG_WE_O && !BUSY_O;
  endsequence
  // ==========================================================
  // Timing of strobes
  AST_WORD_TWO: assert property (take && word |=> s_lo ##1 s_hi)
    else $error("word op strobes wrong");
  AST_BYTE_ONE: assert property (take && !word && OP_I <= 5'h10 |=> WE_O && !BUSY_O)
    else $error("byte op strobe wrong");
  AST_WE_CAUSE: assert property (WE_O |-> $past(take) || $past(BUSY_O))
    else $error("write strobe without request");
  AST_UNK_OP: assert property (take && OP_I > 5'h10 |=> !WE_O && !SREG_WE_O)
    else $error("unknown op wrote");
  AST_HOLD: assert property (!START_I && !BUSY_O |=> $stable(RESULT_O))
    else $error("result moved while idle");
  // ==========================================================
  // Values and flags
  AST_ADD: assert property (take && OP_I == `BALU_OP_ADD && !USE_IMM_I
    |=> RESULT_O == $past(DST_I) + $past(SRC_REG_I)) else $error("add result wrong");
  AST_SUB_C: assert property (take && OP_I == `BALU_OP_SUB && USE_IMM_I
    |=> SREG_O[`BALU_FLAG_C] == ($past(DST_I) < $past(IMM_I))) else $error("sub borrow wrong");
  AST_INC: assert property (take && OP_I == `BALU_OP_INC
    |=> SREG_O[`BALU_FLAG_C] == $past(SREG_I[`BALU_FLAG_C])) else $error("inc changed carry");
  AST_LOGIC: assert property (take && OP_I inside {[5'h06:5'h08], 5'h0B, 5'h0C}
    |=> !SREG_O[`BALU_FLAG_V]) else $error("logic op set overflow");
  AST_COM: assert property (take && OP_I == `BALU_OP_COM
    |=> RESULT_O == ~$past(DST_I) && SREG_O[`BALU_FLAG_C]) else $error("complement wrong");
  AST_TST: assert property (take && OP_I == `BALU_OP_TST |=> RESULT_O == $past(DST_I))
    else $error("test changed value");
endmodule : balu_core_assertions
bind balu_core balu_core_assertions u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .START_I(START_I), .OP_I(OP_I), .DST_I(DST_I), .DST_HI_I(DST_HI_I),
  .SRC_REG_I(SRC_REG_I), .IMM_I(IMM_I), .USE_IMM_I(USE_IMM_I), .SREG_I(SREG_I),
  .RESULT_O(RESULT_O), .WE_O(WE_O), .WE_HI_O(WE_HI_O), .SREG_O(SREG_O),
  .SREG_WE_O(SREG_WE_O), .BUSY_O(BUSY_O));
`default_nettype wire

// file: testbench/balu_dec_model.sv
// Purpose : Register file side that feeds operands and takes results
// Assumes : Operands packed {flags, source, pair high, destination}
// Notes   : A load from the bench wins over a write-back
`default_nettype none
module balu_dec_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ld_i,     // Load fresh operands
  input  wire logic [31:0] ld_val_i, // Operands to load
  input  wire logic [7:0]  res_i,    // Result byte
  input  wire logic        we_i,     // Result write strobe
  input  wire logic        we_hi_i,  // Result is pair high byte
  input  wire logic [7:0]  sreg_i,   // New flags
  input  wire logic        sreg_we_i,// Flag write strobe
  output logic      [31:0] regs_o    // Operands held for the unit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Holds operands and writes results back like a register file
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      regs_o <= '0;
    else if (ld_i)
      regs_o <= ld_val_i;
    else
    begin
      if (we_i)
        regs_o[(we_hi_i ? 15 : 7) -: 8] <= res_i;
      if (sreg_we_i)
        regs_o[31:24] <= sreg_i;
    end
  end
endmodule : balu_dec_model
`default_nettype wire

// file: testbench/byte_arithmetic_logic_unit_tb.sv
// Purpose : Self-checking bench against an integer reference model
// Assumes : Flags C0 Z1 N2 V3 S4 H5, unlisted flags pass through
// Notes   : Word ops hold START into the busy cycle to test refusal
`default_nettype none
module byte_arithmetic_logic_unit_tb import balu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, start, use_imm, ld, we, we_hi, sreg_we, busy;
  balu_op_t    op;
  logic [7:0]  imm, result, sreg_n;
  logic [31:0] ld_val, regs;
  int          miscompares, compares, cycles;
  balu_core uut (.CLK_I(clk), .SYS_RST_I(rst), .START_I(start), .OP_I(op),
    .DST_I(regs[7:0]), .DST_HI_I(regs[15:8]), .SRC_REG_I(regs[23:16]), .IMM_I(imm),
    .USE_IMM_I(use_imm), .SREG_I(regs[31:24]), .RESULT_O(result), .WE_O(we),
    .WE_HI_O(we_hi), .SREG_O(sreg_n), .SREG_WE_O(sreg_we), .BUSY_O(busy));
  balu_dec_model u_regs (.clk_i(clk), .rst_i(rst), .ld_i(ld), .ld_val_i(ld_val),
    .res_i(result), .we_i(we), .we_hi_i(we_hi), .sreg_i(sreg_n), .sreg_we_i(sreg_we),
    .regs_o(regs));
  // ==========================================================
  // Reference model: returns {flags, high byte, low byte}
  function automatic int ref_op(int op, int d, int h, int s, int k, int ui, int sr);
    int b, c, r, f;
    b = ui ? k : s;
    c = sr & 1;
    f = sr;
    f[3] = 0;
    case (op)
      0, 1: begin r = d + b + (op == 1 ? c : 0); f[0] = r > 255;
        f[5] = d % 16 + b % 16 + (op == 1 ? c : 0) > 15; f[3] = d[7] == b[7] && r[7] != d[7]; end
      3, 4: begin r = d - b - (op == 4 ? c : 0); f[0] = r < 0;
        f[5] = d % 16 < b % 16 + (op == 4 ? c : 0); f[3] = d[7] != b[7] && r[7] != d[7]; end
      2, 5: begin r = h * 256 + d + (op == 2 ? k : -k); f[0] = r > 65535 || r < 0;
        r &= 65535; f[3] = op == 2 ? h < 128 && r[15] : h > 127 && !r[15];
        f[1] = r == 0; f[2] = r[15]; f[4] = f[2] ^ f[3]; return r | (f << 16); end
      6: r = d & b;
      7: r = d | b;
      8: r = d ^ s;
      9: begin r = 255 - d; f[0] = 1; end
      10: begin r = -d; f[0] = d != 0; f[5] = d % 16 != 0; f[3] = d == 128; end
      11: r = d | k;
      12: r = d & ~k;
      13: begin r = d + 1; f[3] = d == 127; end
      14: begin r = d - 1; f[3] = d == 128; end
      15: r = d;
      default: r = 0;
    endcase
    r &= 255;
    f[1] = r == 0;
    f[2] = r[7];
    return r | (f << 16);
  endfunction : ref_op
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Loads operands, issues one request and checks every strobe cycle
  task automatic run(input balu_op_t opv);
    int d, h, s, k, ui, sr, e;
    logic word;
    d = (opv inside {10, 13, 14} && $urandom % 2) ? (opv == 13 ? 127 : 128) : $urandom % 256;
    h = $urandom % 256;
    s = $urandom % 256;
    k = $urandom % 256;
    ui = $urandom % 2;
    sr = $urandom % 256;
    e = ref_op(opv, d, h, s, k, ui, sr);
    word = opv inside {2, 5};
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= {sr[7:0], s[7:0], h[7:0], d[7:0]};
    imm <= k[7:0];
    use_imm <= ui[0];
    op <= opv;
    @(posedge clk);
    ld <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= word;
    #1;
    if (opv > 16)
      check({we, sreg_we}, 0);
    else
    begin
      check({we, sreg_we, busy, we_hi}, {2'b11, word, 1'b0});
      check(result, e[7:0]);
      check(sreg_n, e[23:16]);
    end
    if (word && opv <= 16)
    begin
      @(posedge clk);
      start <= 1'b0;
      #1 check({we, we_hi, sreg_we, busy, result}, {4'b1100, e[15:8]});
    end
    @(posedge clk);
    start <= 1'b0;
    #1 check({we, sreg_we}, 0);
    $display("test op %h done", opv);
  endtask : run
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    {rst, start, ld, use_imm, op, imm, ld_val} = '0;
    rst = 1'b1;
    void'($urandom(32047));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 check({result, we, we_hi, sreg_n, sreg_we, busy}, 0);
    for (int i = 0; i <= 16; i++)
      run(5'(i));
    run(5'h1F);
    repeat (80) run(5'($urandom % 20));
    summarize();
  end
endmodule : byte_arithmetic_logic_unit_tb
`default_nettype wire
